//--- hw/spi_flash_select_clock_frontend.sv
// serial flash front end: select framing, standby entry and clock-edge data movement
`timescale 1ns/1ns
// Behaviour
// - selected only while chip select held low
// - release of select enters standby
// - operations framed by select fall and rise
// - standby waits for internal program/erase finish
// - input bits captured on rising clock
// - output bits updated on falling clock
// - quad mode moves four bits per clock
// - continuous read starts with quad address
// - deselected: outputs released, input ignored
// - dual/quad reads turn input line into output
module spi_flash_select_clock_frontend
	import flash_fe_pkg::*;
(
	input  wire logic       ref_clk_i,      // core clock
	input  wire logic       rst_i,          // asynchronous reset, active high
	input  wire logic       ce_i,           // core clock enable
	input  wire logic       sck_i,          // serial clock from the host
	input  wire logic       cs_n_i,         // chip select, active low
	input  wire logic [3:0] io_i,           // data lines in
	output logic      [3:0] io_o,           // data lines out
	output logic      [3:0] io_oe_o,        // data line drive enables
	input  wire logic       busy_i,         // internal program/erase running
	input  wire logic       xip_i,          // continuous read armed
	input  wire logic [1:0] rx_mode_i,      // input lines for current phase
	input  wire logic [1:0] tx_mode_i,      // output lines for current phase
	input  wire logic       tx_en_i,        // output phase active
	input  wire logic [7:0] tx_byte_i,      // next read byte
	output logic            tx_req_o,       // pulse: next read byte wanted
	output logic      [7:0] rx_byte_o,      // received byte
	output logic            rx_valid_o,     // pulse: rx_byte_o is new
	output logic            rx_first_o,     // received byte opens the frame
	output logic            cont_read_o,    // frame opened in continuous read
	output logic            selected_o,     // device selected
	output logic            standby_o,      // device in standby
	output logic            frame_start_o,  // pulse: select fell
	output logic            frame_end_o     // pulse: select rose
);
	link_if lk ();

	// ------------------------------------------------------------
	// crossings from the pins and the link
	// ------------------------------------------------------------
	logic [2:0] sync_q;          // {tx toggle, rx toggle, chip select}
	logic       cs_n_st;         // accepted chip select level
	logic       rx_tgl_st;       // accepted rx toggle
	logic       tx_tgl_st;       // accepted tx toggle

	sync3 #(
		.W       (3),
		.RST_VAL ({1'b0, 1'b0, CS_IDLE})
	) u_sync (
		.clk_i (ref_clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.d_i   ({lk.tx_tgl, lk.rx_tgl, cs_n_i}),
		.q_o   (sync_q)
	);

	assign cs_n_st   = sync_q[0];
	assign rx_tgl_st = sync_q[1];
	assign tx_tgl_st = sync_q[2];

	// serial side shifters; rising and falling edges fixed for both idle levels
	flash_link_shifter u_link (
		.sck_i   (sck_i),
		.rst_i   (rst_i),
		.cs_n_i  (cs_n_i),
		.io_i    (io_i),
		.io_o    (io_o),
		.io_oe_o (io_oe_o),
		.lk      (lk)
	);

	// ------------------------------------------------------------
	// power state and framing
	// ------------------------------------------------------------
	power_state_t state_r, state_nxt;       // standby / active / finishing
	logic         sel_r, sel_nxt;           // selected flag
	logic         stby_r, stby_nxt;         // standby flag
	logic         fstart_r, fstart_nxt;     // frame start pulse
	logic         fend_r, fend_nxt;         // frame end pulse
	logic         xipf_r, xipf_nxt;         // frame opened in continuous read

	// next power state from the accepted select level and busy
	always_comb begin
		state_nxt  = state_r;
		fstart_nxt = 1'b0;
		fend_nxt   = 1'b0;
		xipf_nxt   = xipf_r;
		unique case (state_r)
			ST_ACTIVE: begin
				if (cs_n_st) begin
					fend_nxt  = 1'b1;
					state_nxt = busy_i ? ST_FINISH : ST_STANDBY;
				end
			end
			ST_FINISH: begin
				if (!cs_n_st) begin
					fstart_nxt = 1'b1;
					xipf_nxt   = xip_i;
					state_nxt  = ST_ACTIVE;
				end else if (!busy_i) begin
					state_nxt = ST_STANDBY;
				end
			end
			ST_STANDBY: begin
				if (!cs_n_st) begin
					fstart_nxt = 1'b1;
					xipf_nxt   = xip_i;
					state_nxt  = ST_ACTIVE;
				end
			end
		endcase
		sel_nxt  = state_nxt == ST_ACTIVE;
		stby_nxt = state_nxt == ST_STANDBY;
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r  <= ST_STANDBY;
			sel_r    <= 1'b0;
			stby_r   <= 1'b1;
			fstart_r <= 1'b0;
			fend_r   <= 1'b0;
			xipf_r   <= 1'b0;
		end else if (ce_i) begin
			state_r  <= state_nxt;
			sel_r    <= sel_nxt;
			stby_r   <= stby_nxt;
			fstart_r <= fstart_nxt;
			fend_r   <= fend_nxt;
			xipf_r   <= xipf_nxt;
		end
	end

	// ------------------------------------------------------------
	// byte hand-over and link configuration
	// ------------------------------------------------------------
	logic       rx_seen_r, rx_seen_nxt;     // last rx toggle acted on
	logic       tx_seen_r, tx_seen_nxt;     // last tx toggle acted on
	logic [7:0] rxb_r, rxb_nxt;             // received byte
	logic       rxv_r, rxv_nxt;             // received byte pulse
	logic       rxf_r, rxf_nxt;             // first byte flag
	logic       txq_r, txq_nxt;             // next byte request pulse
	logic [7:0] txh_r, txh_nxt;             // byte held for the link
	lane_mode_t rxm_r, rxm_nxt;             // input lines to the link
	lane_mode_t txm_r, txm_nxt;             // output lines to the link
	logic       txe_r, txe_nxt;             // output phase to the link

	// received bytes and read requests pass only while selected; otherwise txh_r follows tx_byte_i and stale toggles are absorbed
	always_comb begin
		rx_seen_nxt = rx_tgl_st;
		tx_seen_nxt = tx_tgl_st;
		rxb_nxt     = rxb_r;
		rxf_nxt     = rxf_r;
		rxv_nxt     = 1'b0;
		txq_nxt     = 1'b0;
		txh_nxt     = txh_r;
		if (rx_tgl_st != rx_seen_r && sel_r) begin
			rxb_nxt = lk.rx_byte;
			rxf_nxt = lk.rx_first;
			rxv_nxt = 1'b1;
		end
		if (!sel_r) begin
			txh_nxt = tx_byte_i;
		end else if (tx_tgl_st != tx_seen_r) begin
			txh_nxt = tx_byte_i;
			txq_nxt = 1'b1;
		end
		if (sel_r) begin
			rxm_nxt = lane_mode_t'(rx_mode_i);
			txm_nxt = lane_mode_t'(tx_mode_i);
			txe_nxt = tx_en_i;
		end else begin
			rxm_nxt = xip_i ? LANE_X4 : LANE_X1;
			txm_nxt = LANE_X1;
			txe_nxt = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_seen_r <= 1'b0;
			tx_seen_r <= 1'b0;
			rxb_r     <= BYTE_RST;
			rxv_r     <= 1'b0;
			rxf_r     <= 1'b0;
			txq_r     <= 1'b0;
			txh_r     <= BYTE_RST;
			rxm_r     <= LANE_X1;
			txm_r     <= LANE_X1;
			txe_r     <= 1'b0;
		end else if (ce_i) begin
			rx_seen_r <= rx_seen_nxt;
			tx_seen_r <= tx_seen_nxt;
			rxb_r     <= rxb_nxt;
			rxv_r     <= rxv_nxt;
			rxf_r     <= rxf_nxt;
			txq_r     <= txq_nxt;
			txh_r     <= txh_nxt;
			rxm_r     <= rxm_nxt;
			txm_r     <= txm_nxt;
			txe_r     <= txe_nxt;
		end
	end

	assign lk.tx_byte  = txh_r;
	assign lk.rx_mode  = rxm_r;
	assign lk.tx_mode  = txm_r;
	assign lk.tx_en    = txe_r;

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign selected_o    = sel_r;
	assign standby_o     = stby_r;
	assign frame_start_o = fstart_r;
	assign frame_end_o   = fend_r;
	assign rx_byte_o     = rxb_r;
	assign rx_valid_o    = rxv_r;
	assign rx_first_o    = rxf_r;
	assign cont_read_o   = xipf_r;
	assign tx_req_o      = txq_r;

	// ------------------------------------------------------------
	// checks: select and power state
	// ------------------------------------------------------------
	// chip select held low for the filter time
	sequence held_low_s;
		(!cs_n_i && ce_i) [*6];
	endsequence

	// chip select high with no internal cycle running
	sequence held_high_idle_s;
		(cs_n_i && ce_i && !busy_i) [*6];
	endsequence

	// finishing state that sees release and an idle array
	sequence finish_idle_s;
		!selected_o && !standby_o && cs_n_st && !busy_i && ce_i;
	endsequence

	// a steady low select must end in the selected state
	select_follow_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		held_low_s |-> selected_o && !standby_o)
		else $error("device not selected while chip select held low");

	// a steady release with no internal cycle must end in standby
	standby_entry_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		held_high_idle_s |-> standby_o && !selected_o)
		else $error("device not in standby after release");

	// while an internal cycle runs, standby is never entered
	busy_defer_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		busy_i && ce_i && !standby_o |=> !standby_o)
		else $error("standby entered while internal cycle runs");

	// the finishing state leaves for standby once the cycle is over
	finish_done_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		finish_idle_s |=> standby_o)
		else $error("standby not entered after internal cycle ended");

	// ------------------------------------------------------------
	// checks: framing and hand-over
	// ------------------------------------------------------------
	// released select leaves every line undriven
	deselect_hiz_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		cs_n_i |-> io_oe_o == LANE_OFF)
		else $error("lines driven while deselected");

	// no byte reaches the core side while deselected
	ignore_idle_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!selected_o |=> !rx_valid_o)
		else $error("byte delivered while deselected");

	// no read byte is requested while deselected
	req_idle_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!selected_o |=> !tx_req_o)
		else $error("read byte requested while deselected");

	// frame start is a one-cycle pulse together with selection
	frame_pulse_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		frame_start_o |-> selected_o ##1 !frame_start_o)
		else $error("frame start not a single pulse on selection");

	// every rise of the selected flag is announced
	start_rise_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$rose(selected_o) |-> frame_start_o)
		else $error("selection without a frame start pulse");

	// frame end only after a selected cycle
	frame_end_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		frame_end_o |-> !selected_o && $past(selected_o))
		else $error("frame end without a prior selection");

	// every fall of the selected flag is announced
	end_fall_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$fell(selected_o) |-> frame_end_o)
		else $error("deselection without a frame end pulse");

	// idle link setup: quad input when continuous read is armed
	xip_mode_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!selected_o && xip_i && ce_i |=> lk.rx_mode == LANE_X4)
		else $error("continuous read frame not prepared for quad address");

	// idle link setup: single input and output off otherwise
	x1_mode_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!selected_o && !xip_i && ce_i |=> lk.rx_mode == LANE_X1 && !lk.tx_en)
		else $error("idle link not set to single input with output off");

	// the continuous read flag follows the armed level at frame start
	cont_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		frame_start_o && $past(ce_i) |-> cont_read_o == $past(xip_i))
		else $error("continuous read flag does not match the armed level");
endmodule : spi_flash_select_clock_frontend

//--- shared/flash_fe_pkg.sv
// shared constants, types and decode helpers for the serial flash front end
package flash_fe_pkg;

	// ------------------------------------------------------------
	// widths and reset values
	// ------------------------------------------------------------
	localparam int         BYTE_W     = 8;         // bits in one transferred byte
	localparam int         LANE_N     = 4;         // data lines io0..io3
	localparam int         CNT_W      = 3;         // bit position inside a byte
	localparam logic [7:0] BYTE_RST   = 8'h00;     // byte registers after reset
	localparam logic [3:0] LANE_OFF   = 4'h0;      // all lines released
	localparam logic       CS_IDLE    = 1'b1;      // chip select released level
	localparam logic [2:0] CNT_ZERO   = 3'h0;      // bit counter start

	// ------------------------------------------------------------
	// lane modes and power states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {LANE_X1, LANE_X2, LANE_X4} lane_mode_t;
	typedef enum logic [1:0] {ST_STANDBY, ST_ACTIVE, ST_FINISH} power_state_t;

	// bits moved per clock edge for a lane mode
	function automatic logic [3:0] lane_step(input lane_mode_t m);
		unique case (m)
			LANE_X2: lane_step = 4'h2;
			LANE_X4: lane_step = 4'h4;
			default: lane_step = 4'h1;
		endcase
	endfunction : lane_step

	// lines driven while reading out in a lane mode
	function automatic logic [3:0] lane_oe(input lane_mode_t m);
		unique case (m)
			LANE_X2: lane_oe = 4'h3;
			LANE_X4: lane_oe = 4'hF;
			default: lane_oe = 4'h2;
		endcase
	endfunction : lane_oe

endpackage : flash_fe_pkg

//--- shared/link_if.sv
// carrier between the core side and the serial clock side of the front end
`timescale 1ns/1ns
interface link_if;
	import flash_fe_pkg::*;

	logic [7:0] rx_byte;   // last complete input byte, held until the next
	logic       rx_first;  // held byte is the first of its frame
	logic       rx_tgl;    // flips once per completed input byte
	logic [7:0] tx_byte;   // next byte to shift out, held by the core
	logic       tx_tgl;    // flips each time tx_byte is taken
	lane_mode_t rx_mode;   // lines used for input
	lane_mode_t tx_mode;   // lines used for output
	logic       tx_en;     // output phase active

	modport core (input rx_byte, rx_first, rx_tgl, tx_tgl,
		output tx_byte, rx_mode, tx_mode, tx_en);
	modport link (output rx_byte, rx_first, rx_tgl, tx_tgl,
		input tx_byte, rx_mode, tx_mode, tx_en);
endinterface : link_if

//--- hw/sync3.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module sync3
	import flash_fe_pkg::*;
#(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] s1_r, s2_r, s3_r, q_r;        // stages and accepted value
	logic [W-1:0] s1_nxt, s2_nxt, s3_nxt, q_nxt;

	// ------------------------------------------------------------
	// next values: each stage feeds the next, accepted value takes stage three
	// ------------------------------------------------------------
	always_comb begin
		s1_nxt = d_i;
		s2_nxt = s1_r;
		s3_nxt = s2_r;
		q_nxt  = q_r;
		for (int i = 0; i < W; i++) begin
			if (s2_r[i] == s3_r[i]) begin
				q_nxt[i] = s3_r[i];     // stable for two samples
			end
		end
	end

	// registers, frozen while the clock enable is low
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
			q_r  <= RST_VAL;
		end else if (ce_i) begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
			q_r  <= q_nxt;
		end
	end

	assign q_o = q_r;
endmodule : sync3

//--- hw/flash_link_shifter.sv
// serial clock side: samples input lines on rising edges, drives output on falling edges
`timescale 1ns/1ns
module flash_link_shifter
	import flash_fe_pkg::*;
(
	input  wire logic       sck_i,
	input  wire logic       rst_i,
	input  wire logic       cs_n_i,
	input  wire logic [3:0] io_i,
	output logic      [3:0] io_o,
	output logic      [3:0] io_oe_o,
	link_if.link            lk
);
	logic       frame_rst;                      // reset or released select
	logic [4:0] cfg_in, cfg_q;                  // config level crossing
	lane_mode_t rx_mode, tx_mode;               // crossed modes
	logic       tx_en;                          // crossed output phase
	logic [7:0] rx_sh_r, rx_sh_nxt;             // input shifter
	logic [2:0] rx_cnt_r, rx_cnt_nxt;           // input bit position
	logic       rx_fst_r, rx_fst_nxt;           // first byte still pending
	logic       done;                           // byte completes this edge
	logic [7:0] rx_byte_r, rx_byte_nxt;         // held byte for the core
	logic       rx_first_r, rx_first_nxt;
	logic       rx_tgl_r, rx_tgl_nxt;
	logic [7:0] tx_sh_r, tx_sh_nxt;             // output shifter
	logic [2:0] tx_cnt_r, tx_cnt_nxt;           // output bit position
	logic [3:0] io_r, io_nxt, oe_r, oe_nxt;     // pin registers
	logic       tx_tgl_r, tx_tgl_nxt;
	logic [3:0] rstep, tstep;

	// outside a frame the shifter, counter and pin registers are held at their reset values
	assign frame_rst = rst_i | cs_n_i;
	assign cfg_in    = {lk.tx_en, lk.tx_mode, lk.rx_mode};
	assign rx_mode   = lane_mode_t'(cfg_q[1:0]);
	assign tx_mode   = lane_mode_t'(cfg_q[3:2]);
	assign tx_en     = cfg_q[4];
	assign rstep     = lane_step(rx_mode);
	assign tstep     = lane_step(tx_mode);

	// config crossing from the core clock; it only advances while sck runs,
	// so modes must be set a few serial clocks before they are used
	sync3 #(
		.W       (5),
		.RST_VAL (5'h00)
	) u_cfg_sync (
		.clk_i (sck_i),
		.rst_i (rst_i),
		.ce_i  (1'b1),
		.d_i   (cfg_in),
		.q_o   (cfg_q)
	);

	// ------------------------------------------------------------
	// rising edge: capture input bits
	// ------------------------------------------------------------
	always_comb begin
		rx_sh_nxt    = rx_sh_r;
		rx_cnt_nxt   = rx_cnt_r + rstep[2:0];
		rx_fst_nxt   = rx_fst_r;
		rx_byte_nxt  = rx_byte_r;
		rx_first_nxt = rx_first_r;
		rx_tgl_nxt   = rx_tgl_r;
		done         = ({1'b0, rx_cnt_r} + rstep) == 4'h8;
		unique case (rx_mode)
			LANE_X4: rx_sh_nxt = {rx_sh_r[3:0], io_i};
			LANE_X2: rx_sh_nxt = {rx_sh_r[5:0], io_i[1:0]};
			default: rx_sh_nxt = {rx_sh_r[6:0], io_i[0]};
		endcase
		if (done) begin
			rx_byte_nxt  = rx_sh_nxt;
			rx_first_nxt = rx_fst_r;
			rx_fst_nxt   = 1'b0;
			rx_tgl_nxt   = ~rx_tgl_r;
		end
	end

	// frame state restarts on every select
	always_ff @(posedge sck_i or posedge frame_rst) begin
		if (frame_rst) begin
			rx_sh_r  <= BYTE_RST;
			rx_cnt_r <= CNT_ZERO;
			rx_fst_r <= 1'b1;
		end else begin
			rx_sh_r  <= rx_sh_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			rx_fst_r <= rx_fst_nxt;
		end
	end

	// hand-over survives deselection
	always_ff @(posedge sck_i or posedge rst_i) begin
		if (rst_i) begin
			rx_byte_r  <= BYTE_RST;
			rx_first_r <= 1'b0;
			rx_tgl_r   <= 1'b0;
		end else begin
			if (!cs_n_i) begin
				rx_byte_r  <= rx_byte_nxt;
				rx_first_r <= rx_first_nxt;
				rx_tgl_r   <= rx_tgl_nxt;
			end
		end
	end

	// ------------------------------------------------------------
	// falling edge: drive output bits
	// ------------------------------------------------------------
	always_comb begin
		logic [7:0] src;
		src        = (tx_cnt_r == CNT_ZERO) ? lk.tx_byte : tx_sh_r;
		tx_tgl_nxt = tx_tgl_r;
		io_nxt     = io_r;
		oe_nxt     = tx_en ? lane_oe(tx_mode) : LANE_OFF;
		tx_cnt_nxt = tx_cnt_r;
		tx_sh_nxt  = tx_sh_r;
		if (tx_en) begin
			tx_cnt_nxt = tx_cnt_r + tstep[2:0];
			tx_sh_nxt  = src << tstep;
			if (tx_cnt_r == CNT_ZERO) begin
				tx_tgl_nxt = ~tx_tgl_r;
			end
			unique case (tx_mode)
				LANE_X4: io_nxt = src[7:4];
				LANE_X2: io_nxt = {2'h0, src[7:6]};
				default: io_nxt = {2'h0, src[7], 1'b0};
			endcase
		end
	end

	always_ff @(negedge sck_i or posedge frame_rst) begin
		if (frame_rst) begin
			tx_sh_r  <= BYTE_RST;
			tx_cnt_r <= CNT_ZERO;
			io_r     <= LANE_OFF;
			oe_r     <= LANE_OFF;
		end else begin
			tx_sh_r  <= tx_sh_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			io_r     <= io_nxt;
			oe_r     <= oe_nxt;
		end
	end

	always_ff @(negedge sck_i or posedge rst_i) begin
		if (rst_i) begin
			tx_tgl_r <= 1'b0;
		end else if (!cs_n_i) begin
			tx_tgl_r <= tx_tgl_nxt;
		end
	end

	assign io_o        = io_r;
	assign io_oe_o     = oe_r;
	assign lk.rx_byte  = rx_byte_r;
	assign lk.rx_first = rx_first_r;
	assign lk.rx_tgl   = rx_tgl_r;
	assign lk.tx_tgl   = tx_tgl_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	quad_drive_a: assert property (@(negedge sck_i) disable iff (frame_rst)
		tx_en && tx_mode == LANE_X4 |=> oe_r == 4'hF)
		else $error("quad output does not drive all four lines");
	byte_count_a: assert property (@(posedge sck_i) disable iff (frame_rst)
		rx_mode == LANE_X1 && rx_cnt_r == 3'h7 && !cs_n_i |=> rx_tgl_r != $past(rx_tgl_r))
		else $error("eighth single-line bit did not complete a byte");
endmodule : flash_link_shifter

//--- tb/flash_host_model.sv
// host controller model: drives select, serial clock and the input lines
`timescale 1ns/1ns
module flash_host_model (
	output logic       sck_o,  // serial clock, also toggled between frames by idle
	output logic       cs_n_o, // chip select, active low
	output logic [3:0] io_o    // host drive of the data lines
);
	logic cpol; // clock idle level, set by the bench

	initial begin
		cpol = 1'b0;
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		io_o = 4'h0;
	end

	// one 64 ns clock period: low half with new data, then the sampling edge
	task automatic tick(input logic [3:0] d);
		sck_o = 1'b0;
		io_o = d;
		#32;
		sck_o = 1'b1;
		#32;
	endtask : tick

	// falling select opens an operation
	task automatic open_frame();
		sck_o = cpol;
		#64;
		cs_n_o = 1'b0;
		#64;
	endtask : open_frame

	// clock back to idle level, then rising select ends the operation
	task automatic close_frame();
		sck_o = cpol;
		#32;
		cs_n_o = 1'b1;
		#64;
	endtask : close_frame

	// one byte, msb first; unused lines toggle so old values never linger
	task automatic send(input logic [7:0] b, input int lanes);
		for (int i = 0; i < 8 / lanes; i++) begin
			if (lanes == 4) tick(i == 0 ? b[7:4] : b[3:0]);
			else tick({~io_o[3:1], b[7 - i]});
		end
	endtask : send

	// clocks with toggling lines, used for reads and idle activity
	task automatic idle(input int n);
		for (int i = 0; i < n; i++) tick(~io_o);
	endtask : idle
endmodule : flash_host_model

//--- tb/spi_flash_select_clock_frontend_bench.sv
// self-checking bench for the serial flash front end
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module spi_flash_select_clock_frontend_bench;
	import flash_fe_pkg::*;
	logic       ref_clk_i, rst_i, ce_i, busy_i, xip_i, tx_en_i;
	logic [1:0] rx_mode_i, tx_mode_i;
	logic [7:0] tx_byte_i, rx_byte_o, last_byte;
	logic [3:0] io_o, io_oe_o, host_io;
	wire  [3:0] io_i;
	wire        sck_i, cs_n_i;
	logic       tx_req_o, rx_valid_o, rx_first_o, cont_read_o, last_first;
	logic       selected_o, standby_o, frame_start_o, frame_end_o;
	logic [7:0] rd_q[$]; // {drive enables, wire levels} at each sampling edge while selected and driving
	int         mismatches, checked, n_rx, n_start, n_end, n_req, cyc;

	// wire level: device where it drives, host otherwise
	assign io_i = (io_oe_o & io_o) | (~io_oe_o & host_io);

	flash_host_model i_flash_host_model (.sck_o(sck_i), .cs_n_o(cs_n_i), .io_o(host_io));
	spi_flash_select_clock_frontend i_spi_flash_select_clock_frontend (.ref_clk_i, .rst_i,
		.ce_i, .sck_i, .cs_n_i, .io_i, .io_o, .io_oe_o, .busy_i, .xip_i, .rx_mode_i,
		.tx_mode_i, .tx_en_i, .tx_byte_i, .tx_req_o, .rx_byte_o, .rx_valid_o, .rx_first_o,
		.cont_read_o, .selected_o, .standby_o, .frame_start_o, .frame_end_o);

	// ------------------------------------------------------------
	// monitors and timeout
	// ------------------------------------------------------------
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	always @(negedge ref_clk_i) begin
		if (rx_valid_o === 1'b1) begin
			n_rx++;
			last_byte = rx_byte_o;
			last_first = rx_first_o;
		end
		if (frame_start_o === 1'b1) n_start++;
		if (frame_end_o === 1'b1) n_end++;
		if (tx_req_o === 1'b1) n_req++;
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			test_done();
		end
	end
	always @(posedge sck_i) if (!cs_n_i && io_oe_o !== 4'h0) rd_q.push_back({io_oe_o, io_i});

	task automatic wait_ref(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask : wait_ref

	// deselected clocks let the link take up new modes before the next frame
	task automatic flush();
		wait_ref(4);
		i_flash_host_model.idle(4);
		wait_ref(1);
	endtask : flush

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_write(input logic [7:0] b);
		int n0 = n_rx;
		int s0 = n_start;
		int e0 = n_end;
		i_flash_host_model.open_frame();
		i_flash_host_model.send(b, 1);
		wait_ref(8);
		`CHK(selected_o, 1'b1)
		`CHK(standby_o, 1'b0)
		`CHK(last_byte, b)
		`CHK(last_first, 1'b1)
		i_flash_host_model.close_frame();
		wait_ref(8);
		`CHK(n_rx - n0, 1)
		`CHK(n_start - s0, 1)
		`CHK(n_end - e0, 1)
		`CHK(standby_o, 1'b1)
		`CHK(io_oe_o, 4'h0)
	endtask : t_write

	// clock activity while deselected must leave no trace
	task automatic t_ignore();
		int n0 = n_rx;
		i_flash_host_model.idle(16);
		wait_ref(8);
		`CHK(n_rx - n0, 0)
		`CHK(selected_o, 1'b0)
		`CHK(io_oe_o, 4'h0)
	endtask : t_ignore

	// continuous read: no opcode, quad address nibbles from the first edge
	task automatic t_quad();
		xip_i <= 1'b1;
		rx_mode_i <= 2'h2;
		flush();
		i_flash_host_model.open_frame();
		i_flash_host_model.send(8'h5A, 4);
		wait_ref(8);
		`CHK(last_byte, 8'h5A)
		`CHK(last_first, 1'b1)
		`CHK(cont_read_o, 1'b1)
		i_flash_host_model.send(8'hC3, 4);
		wait_ref(8);
		`CHK(last_byte, 8'hC3)
		`CHK(last_first, 1'b0)
		i_flash_host_model.close_frame();
		wait_ref(1);
		xip_i <= 1'b0;
		rx_mode_i <= 2'h0;
		flush();
	endtask : t_quad

	// release during a program cycle keeps the device out of standby
	task automatic t_busy();
		busy_i <= 1'b1;
		i_flash_host_model.open_frame();
		i_flash_host_model.send(8'h0F, 1);
		i_flash_host_model.close_frame();
		wait_ref(8);
		`CHK(selected_o, 1'b0)
		`CHK(standby_o, 1'b0)
		busy_i <= 1'b0;
		wait_ref(8);
		`CHK(standby_o, 1'b1)
	endtask : t_busy

	// read out one byte; the first driven samples must carry it msb first
	task automatic t_read(input lane_mode_t mode, input logic [7:0] b, input int n);
		int r0 = n_req;
		int steps = (mode == LANE_X4) ? 2 : (mode == LANE_X2) ? 4 : 8;
		logic [7:0] got;
		tx_mode_i <= mode;
		tx_byte_i <= b;
		tx_en_i <= 1'b1;
		wait_ref(4);
		rd_q.delete();
		i_flash_host_model.open_frame();
		i_flash_host_model.idle(n);
		`CHK(rd_q.size() >= steps, 1'b1)
		for (int i = 0; i < steps; i++) begin
			got = rd_q[i];
			if (mode == LANE_X4) `CHK(got, {4'hF, i == 0 ? b[7:4] : b[3:0]})
			else if (mode == LANE_X2) `CHK({got[7:4], got[1:0]}, {4'h3, b[7 - 2 * i -: 2]})
			else `CHK({got[7:4], got[1]}, {4'h2, b[7 - i]})
		end
		`CHK(n_req > r0, 1'b1)
		i_flash_host_model.close_frame();
		`CHK(io_oe_o, 4'h0)
		wait_ref(1);
		tx_en_i <= 1'b0;
		flush();
	endtask : t_read

	task automatic test_done();
		if (mismatches == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rst_i = 1'b1;
		ce_i = 1'b1;
		busy_i = 1'b0;
		xip_i = 1'b0;
		rx_mode_i = 2'h0;
		tx_mode_i = 2'h0;
		tx_en_i = 1'b0;
		tx_byte_i = 8'h00;
		wait_ref(20);
		rst_i <= 1'b0;
		wait_ref(2);
		`CHK(standby_o, 1'b1)
		`CHK(io_oe_o, 4'h0)
		t_write(8'hA5);
		t_ignore();
		t_quad();
		t_busy();
		t_read(LANE_X1, 8'hB4, 12);
		t_read(LANE_X2, 8'h6D, 9);
		t_read(LANE_X4, 8'hE1, 7);
		i_flash_host_model.cpol = 1'b1; // clock idles high from here on
		t_write(8'h96);
		test_done();
	end
endmodule : spi_flash_select_clock_frontend_bench
